// ---- rtl/fra_map.svh ----
// fra_map.svh: constants for the floating point register access block
`ifndef FRA_MAP_SVH
`define FRA_MAP_SVH

// register file shape
`define FRA_NUM_FPR 32
`define FRA_FPR_RESET 64'h0000_0000_0000_0000

// control/status word layout and reset value
`define FRA_CSR_RESET 32'h0000_0000
`define FRA_UNIMPL_BIT 17
`define FRA_CAUSE_HI 16
`define FRA_CAUSE_LO 12
`define FRA_ENABLE_HI 11
`define FRA_ENABLE_LO 7
`define FRA_CC0_BIT 23
`define FRA_CC_BASE 24

// apb register byte offsets
`define FRA_OFS_CSR 12'h000
`define FRA_OFS_STATUS 12'h004
`define FRA_OFS_FPR_SEL 12'h008
`define FRA_OFS_FPR_LO 12'h00c
`define FRA_OFS_FPR_HI 12'h010

// status register bit positions
`define FRA_STAT_EXC_BIT 0
`define FRA_STAT_MODE_BIT 1

`endif

// ---- rtl/fra_pkg.sv ----
// fra_pkg.sv: types shared by the fp register access block
`default_nettype none
package fra_pkg;
  // operand formats presented by the datapath
  typedef enum logic [3:0] {
    FMT_SINGLE = 4'h0,
    FMT_DOUBLE = 4'h1,
    FMT_WORD = 4'h2,
    FMT_LONG = 4'h3,
    FMT_PAIRED = 4'h4,
    FMT_OCTBYTE = 4'h5,
    FMT_QUADHALF = 4'h6,
    FMT_RAW_WORD = 4'h7,
    FMT_RAW_DOUBLE = 4'h8
  } fra_fmt_type;
  // register number and values
  typedef logic [4:0] fra_idx_type;
  typedef logic [63:0] fra_val_type;
  typedef logic [2:0] fra_cc_sel_type;
endpackage : fra_pkg
`default_nettype wire

// ---- rtl/fra_csr_logic.sv ----
// fra_csr_logic.sv: condition bit access and exception check on the status word
`include "fra_map.svh"
`default_nettype none
module fra_csr_logic (
  input wire logic [31:0] csr_word,
  input wire fra_pkg::fra_cc_sel_type rd_sel,
  input wire fra_pkg::fra_cc_sel_type wr_sel,
  input wire logic wr_val,
  output logic rd_bit,
  output logic [31:0] csr_after_write,
  output logic exc_raised
);
  import fra_pkg::*;

  // bit position of a condition selector; shared by read and write
  function automatic logic [4:0] fra_cc_pos(input fra_cc_sel_type sel);
    logic [4:0] pos;
    pos = 5'(`FRA_CC_BASE) + {2'h0, sel};
    if (sel == 3'h0) begin
      pos = 5'(`FRA_CC0_BIT);
    end
    return pos;
  endfunction : fra_cc_pos

  // condition bit read, combinational from the stored word
  always_comb begin
    rd_bit = csr_word[fra_cc_pos(rd_sel)];
  end

  // condition bit write: only the selected bit is replaced
  always_comb begin
    csr_after_write = csr_word;
    csr_after_write[fra_cc_pos(wr_sel)] = wr_val;
  end

  // unimplemented cause has no enable; other causes need theirs
  always_comb begin
    exc_raised = csr_word[`FRA_UNIMPL_BIT] |
      (|(csr_word[`FRA_CAUSE_HI:`FRA_CAUSE_LO] & csr_word[`FRA_ENABLE_HI:`FRA_ENABLE_LO]));
  end
endmodule : fra_csr_logic
`default_nettype wire

// ---- rtl/fra_regfile.sv ----
// fra_regfile.sv: fp register file with formatted access and status word
`include "fra_map.svh"
`default_nettype none
module fra_regfile (
  // single clock and asynchronous active-low reset
  input wire logic core_clk,
  input wire logic rst_b,
  // static configuration: high selects the paired 32-bit register mode
  input wire logic paired_register_mode,
  // formatted register read port
  input wire fra_pkg::fra_idx_type rd_reg,
  input wire fra_pkg::fra_fmt_type rd_fmt,
  output fra_pkg::fra_val_type rd_data,
  // formatted register write port
  input wire logic wr_req,
  input wire fra_pkg::fra_idx_type wr_reg,
  input wire fra_pkg::fra_fmt_type wr_fmt,
  input wire fra_pkg::fra_val_type wr_data,
  // exception check for the current instruction
  input wire logic exc_check,
  output logic fp_exception,
  // condition bit read
  input wire fra_pkg::fra_cc_sel_type cc_rd_sel,
  output logic cc_rd_bit,
  // condition bit write
  input wire logic cc_wr_req,
  input wire fra_pkg::fra_cc_sel_type cc_wr_sel,
  input wire logic cc_wr_val,
  // control/status word as seen by the datapath
  output logic [31:0] fp_control_status_word,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import fra_pkg::*;

  // storage: flip-flop register file addressed by index
  fra_val_type fpr [`FRA_NUM_FPR];
  fra_val_type next_fpr [`FRA_NUM_FPR];
  // control/status word
  logic [31:0] csr;
  logic [31:0] next_csr;
  // apb read data and error, captured in the setup cycle
  logic [31:0] next_prdata;
  logic next_pslverr;
  // register picked for the software peek window
  fra_idx_type peek_sel;
  fra_idx_type next_peek_sel;
  // last exception seen by a check, shown in status
  logic exc_seen;
  logic next_exc_seen;
  // helper results from the status word unit
  logic exc_raised;
  logic [31:0] csr_cc_written;
  // decoded transfer phases
  logic apb_setup;
  logic apb_write;
  // writeback allowed for this instruction
  logic commit;

  // status word unit: condition bits and the exception check
  fra_csr_logic u_csr_logic (
    .csr_word(csr),
    .rd_sel(cc_rd_sel),
    .wr_sel(cc_wr_sel),
    .wr_val(cc_wr_val),
    .rd_bit(cc_rd_bit),
    .csr_after_write(csr_cc_written),
    .exc_raised(exc_raised)
  );

  // true when the pair access names an allowed even register
  function automatic logic fra_pair_ok(input fra_idx_type idx);
    return idx[0] == 1'b0;
  endfunction : fra_pair_ok

  // the datapath sees the stored word directly
  assign fp_control_status_word = csr;

  // exception pulse follows the check request
  always_comb begin
    fp_exception = exc_check & exc_raised;
  end

  // an exception kills the rest of the instruction, writes included
  always_comb begin
    commit = ~fp_exception;
  end

  // formatted read; the mode is static so no synchroniser is needed
  // the datapath only asks in the last written format, so no tag is kept
  always_comb begin
    rd_data = 64'h0;
    unique case (rd_fmt)
      FMT_SINGLE, FMT_WORD, FMT_RAW_WORD: begin
        rd_data = fpr[rd_reg];
      end
      FMT_DOUBLE, FMT_RAW_DOUBLE: begin
        if (!paired_register_mode) begin
          rd_data = fpr[rd_reg];
        end else if (fra_pair_ok(rd_reg)) begin
          // next register low half on top, addressed low half below
          rd_data = {fpr[rd_reg + 5'h1][31:0], fpr[rd_reg][31:0]};
        end else begin
          rd_data = 64'h0;
        end
      end
      FMT_LONG, FMT_PAIRED: begin
        if (!paired_register_mode) begin
          rd_data = fpr[rd_reg];
        end else begin
          rd_data = 64'h0;
        end
      end
      default: begin
        // packed-byte, packed-half and illegal codes have no defined value
        rd_data = 64'h0;
      end
    endcase
  end

  // next state of the register file
  always_comb begin
    for (int i = 0; i < `FRA_NUM_FPR; i++) begin
      next_fpr[i] = fpr[i];
    end
    if (wr_req && commit) begin
      unique case (wr_fmt)
        FMT_SINGLE, FMT_WORD, FMT_RAW_WORD: begin
          next_fpr[wr_reg] = wr_data;
        end
        FMT_DOUBLE, FMT_RAW_DOUBLE: begin
          if (!paired_register_mode) begin
            next_fpr[wr_reg] = wr_data;
          end else if (fra_pair_ok(wr_reg)) begin
            // upper halves are undefined; zero keeps them deterministic
            next_fpr[wr_reg] = {32'h0, wr_data[31:0]};
            next_fpr[wr_reg + 5'h1] = {32'h0, wr_data[63:32]};
          end
          // an odd register in paired mode stores nothing
        end
        FMT_LONG, FMT_PAIRED: begin
          if (!paired_register_mode) begin
            next_fpr[wr_reg] = wr_data;
          end
          // paired mode leaves the file untouched
        end
        default: begin
          // undefined formats are dropped
          next_fpr[wr_reg] = fpr[wr_reg];
        end
      endcase
    end
  end

  // register file flops; the write lands on the edge after the request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `FRA_NUM_FPR; i++) begin
        fpr[i] <= `FRA_FPR_RESET;
      end
    end else begin
      for (int i = 0; i < `FRA_NUM_FPR; i++) begin
        fpr[i] <= next_fpr[i];
      end
    end
  end

  // apb phases: setup is psel without penable, write at access
  always_comb begin
    apb_setup = psel & ~penable;
    apb_write = psel & penable & pwrite;
  end

  // next status word: software write first, condition bit on top
  // a datapath condition write in the same cycle therefore wins its bit only if it changes the stored value
  always_comb begin
    next_csr = csr;
    if (apb_write && paddr == `FRA_OFS_CSR) begin
      next_csr = pwdata;
    end
    if (cc_wr_req && commit) begin
      next_csr = csr_cc_written;
      if (apb_write && paddr == `FRA_OFS_CSR) begin
        next_csr = pwdata;
        next_csr[`FRA_CC0_BIT] = csr_cc_written[`FRA_CC0_BIT];
        next_csr[31:`FRA_CC_BASE] = csr_cc_written[31:`FRA_CC_BASE];
        // keep software value on condition bits whose stored value the condition write does not change
        for (int b = `FRA_CC_BASE; b < 32; b++) begin
          if (csr_cc_written[b] == csr[b]) begin
            next_csr[b] = pwdata[b];
          end
        end
        if (csr_cc_written[`FRA_CC0_BIT] == csr[`FRA_CC0_BIT]) begin
          next_csr[`FRA_CC0_BIT] = pwdata[`FRA_CC0_BIT];
        end
      end
    end
  end

  // next value of the sticky exception flag; a new event beats the clear
  always_comb begin
    next_exc_seen = exc_seen;
    if (apb_write && paddr == `FRA_OFS_STATUS && pwdata[`FRA_STAT_EXC_BIT]) begin
      next_exc_seen = 1'b0;
    end
    if (fp_exception) begin
      next_exc_seen = 1'b1;
    end
  end

  // next peek selector for the software window
  always_comb begin
    next_peek_sel = peek_sel;
    if (apb_write && paddr == `FRA_OFS_FPR_SEL) begin
      next_peek_sel = pwdata[4:0];
    end
  end

  // read data prepared in setup, so prdata comes from a flop
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (apb_setup) begin
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      unique case (paddr)
        `FRA_OFS_CSR: begin
          next_prdata = csr;
        end
        `FRA_OFS_STATUS: begin
          next_prdata[`FRA_STAT_EXC_BIT] = exc_seen;
          next_prdata[`FRA_STAT_MODE_BIT] = paired_register_mode;
        end
        `FRA_OFS_FPR_SEL: begin
          next_prdata = {27'h0, peek_sel};
        end
        `FRA_OFS_FPR_LO: begin
          next_prdata = fpr[peek_sel][31:0];
        end
        `FRA_OFS_FPR_HI: begin
          next_prdata = fpr[peek_sel][63:32];
        end
        default: begin
          // unmapped: zero data and an error answer
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // zero wait states: the answer is ready in the access phase
  always_comb begin
    pready = 1'b1;
  end

  // status and bus flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      csr <= `FRA_CSR_RESET;
      exc_seen <= 1'b0;
      peek_sel <= 5'h00;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      csr <= next_csr;
      exc_seen <= next_exc_seen;
      peek_sel <= next_peek_sel;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end
endmodule : fra_regfile
`default_nettype wire

// ---- verification/fra_regfile_checker.sv ----
// fra_regfile_checker.sv: assertions on the fp register block ports
`default_nettype none
module fra_regfile_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic paired_register_mode,
  input wire fra_pkg::fra_idx_type rd_reg,
  input wire fra_pkg::fra_fmt_type rd_fmt,
  input wire fra_pkg::fra_val_type rd_data,
  input wire logic wr_req,
  input wire fra_pkg::fra_idx_type wr_reg,
  input wire fra_pkg::fra_fmt_type wr_fmt,
  input wire fra_pkg::fra_val_type wr_data,
  input wire logic exc_check,
  input wire logic fp_exception,
  input wire fra_pkg::fra_cc_sel_type cc_rd_sel,
  input wire logic cc_rd_bit,
  input wire logic cc_wr_req,
  input wire fra_pkg::fra_cc_sel_type cc_wr_sel,
  input wire logic cc_wr_val,
  input wire logic [31:0] fp_control_status_word,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr
);
  import fra_pkg::*;
  // status word bit picked by each selector
  logic [4:0] rd_idx;
  logic [4:0] wr_idx;
  // software write to the word may legally race a condition write
  logic sw_wr;
  logic [31:0] csr;
  assign csr = fp_control_status_word;
  assign rd_idx = (cc_rd_sel == 3'h0) ? 5'h17 : 5'h18 + 5'(cc_rd_sel);
  assign wr_idx = (cc_wr_sel == 3'h0) ? 5'h17 : 5'h18 + 5'(cc_wr_sel);
  assign sw_wr = psel && penable && pwrite && (paddr == 12'h000);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_cc_read: assert property (cc_rd_bit == csr[rd_idx]) else $error("cc read");
  chk_exc_raise: assert property (fp_exception == (exc_check && (csr[17] || |(csr[16:12] & csr[11:7]))))
    else $error("exception flag");
  chk_cc_bit: assert property (cc_wr_req && !fp_exception && !sw_wr |=> csr[$past(wr_idx)] == $past(cc_wr_val))
    else $error("cc write");
  chk_cc_rest: assert property (cc_wr_req && !fp_exception && !sw_wr |=>
    ((csr ^ $past(csr)) & ~(32'h1 << $past(wr_idx))) == 32'h0) else $error("cc neighbours");
  chk_wr_abort: assert property (wr_req && fp_exception ##1 $stable(rd_reg) && $stable(rd_fmt) |-> $stable(rd_data))
    else $error("aborted write");
  chk_wr_read: assert property (wr_req && !fp_exception && !paired_register_mode && wr_fmt <= FMT_RAW_DOUBLE &&
    !(wr_fmt inside {FMT_OCTBYTE, FMT_QUADHALF}) ##1 rd_reg == $past(wr_reg) && rd_fmt == $past(wr_fmt)
    |-> rd_data == $past(wr_data)) else $error("full write");
  chk_pair_dbl: assert property (paired_register_mode && wr_req && !fp_exception && wr_fmt == FMT_DOUBLE &&
    !wr_reg[0] ##1 rd_reg == $past(wr_reg) && rd_fmt == FMT_DOUBLE |-> rd_data == $past(wr_data)) else $error("pair");
  chk_undef_rd: assert property (rd_fmt > FMT_RAW_DOUBLE || rd_fmt inside {FMT_OCTBYTE, FMT_QUADHALF} ||
    paired_register_mode && (rd_fmt inside {FMT_LONG, FMT_PAIRED} || rd_fmt == FMT_DOUBLE && rd_reg[0])
    |-> rd_data == 64'h0) else $error("undefined read");
endmodule : fra_regfile_checker
bind fra_regfile fra_regfile_checker chk_i (.core_clk, .rst_b, .paired_register_mode, .rd_reg, .rd_fmt, .rd_data,
  .wr_req, .wr_reg, .wr_fmt, .wr_data, .exc_check, .fp_exception, .cc_rd_sel, .cc_rd_bit, .cc_wr_req, .cc_wr_sel,
  .cc_wr_val, .fp_control_status_word, .psel, .penable, .pwrite, .paddr);
`default_nettype wire

// ---- verification/fra_dp_model.sv ----
// fra_dp_model.sv: datapath model issuing register and condition writes
`default_nettype none
module fra_dp_model (
  input wire logic core_clk,
  input wire logic fp_exception,
  output var logic wr_req,
  output var fra_pkg::fra_idx_type wr_reg,
  output var fra_pkg::fra_fmt_type wr_fmt,
  output var fra_pkg::fra_val_type wr_data,
  output var logic exc_check,
  output var logic cc_wr_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import fra_pkg::*;
  // no request stands at time zero
  initial {wr_req, exc_check, cc_wr_req, wr_reg, wr_data} = '0;
  initial wr_fmt = FMT_SINGLE;
  // one request for one cycle; cc picks a condition write, exc returns that cycle's flag
  task automatic dp_op(input logic cc, input fra_idx_type r, input fra_fmt_type f, input fra_val_type d,
      input logic chk, output logic exc);
    @(posedge core_clk);
    wr_req <= !cc;
    cc_wr_req <= cc;
    exc_check <= chk;
    wr_reg <= r;
    wr_fmt <= f;
    wr_data <= d;
    @(negedge core_clk);
    exc = fp_exception;
    @(posedge core_clk);
    {wr_req, cc_wr_req, exc_check} <= 3'h0;
    // released data is inverted so nothing leans on a stale value
    wr_data <= ~d;
  endtask : dp_op
endmodule : fra_dp_model
`default_nettype wire

// ---- verification/test_fp_register_access_and_flags.sv ----
// test_fp_register_access_and_flags.sv: self-checking bench for the fp register block
`default_nettype none
module test_fp_register_access_and_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import fra_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic paired_register_mode = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  fra_idx_type rd_reg = 5'h0;
  fra_fmt_type rd_fmt = FMT_SINGLE;
  fra_cc_sel_type cc_rd_sel = 3'h0;
  fra_idx_type wr_reg;
  fra_fmt_type wr_fmt;
  fra_val_type wr_data, rd_data;
  logic wr_req, exc_check, cc_wr_req, fp_exception, cc_rd_bit, pready, pslverr, e, er;
  logic [31:0] fp_control_status_word, prdata, rv;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  fra_dp_model dp (.core_clk, .fp_exception, .wr_req, .wr_reg, .wr_fmt, .wr_data, .exc_check, .cc_wr_req);
  fra_regfile uut (.core_clk, .rst_b, .paired_register_mode, .rd_reg, .rd_fmt, .rd_data, .wr_req, .wr_reg, .wr_fmt,
    .wr_data, .exc_check, .fp_exception, .cc_rd_sel, .cc_rd_bit, .cc_wr_req, .cc_wr_sel(wr_reg[2:0]),
    .cc_wr_val(wr_data[0]), .fp_control_status_word, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  initial forever #20 core_clk = ~core_clk;
  // a hang is cut short well beyond the fewer than two hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // mode only changes under reset since it is static
  task automatic do_reset(input logic mode);
    @(posedge core_clk);
    rst_b <= 1'b0;
    paired_register_mode <= mode;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask : do_reset
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  // called on a rising edge; the read request lands at once so a write just taken is read back in the next cycle
  task automatic rd(input fra_idx_type r, input fra_fmt_type f, input fra_val_type exp);
    rd_reg <= r;
    rd_fmt <= f;
    @(negedge core_clk);
    check(rd_data, exp);
    @(posedge core_clk);
  endtask : rd
  task automatic t_full();
    fra_fmt_type f;
    for (int i = 0; i < 9; i++) begin
      f = fra_fmt_type'(i);
      if (f inside {FMT_OCTBYTE, FMT_QUADHALF}) continue;
      rd(5'(i + 1), f, 64'h0);
      dp.dp_op(1'b0, 5'(i + 1), f, {32'h5a00_0000 + i, 32'h0000_a5a5}, 1'b0, e);
      rd(5'(i + 1), f, {32'h5a00_0000 + i, 32'h0000_a5a5});
    end
    rd(5'h1, FMT_QUADHALF, 64'h0);
    rd(5'h1, fra_fmt_type'(4'hf), 64'h0);
  endtask : t_full
  task automatic t_cc();
    apb(1'b1, 12'h000, 32'h0040_0f0f);
    for (int s = 0; s < 8; s++) begin
      dp.dp_op(1'b1, 5'(s), FMT_SINGLE, 64'h1, 1'b0, e);
      cc_rd_sel <= 3'(s);
      @(negedge core_clk);
      check(cc_rd_bit, 1'b1);
      check(fp_control_status_word, 32'h0040_0f0f | (32'h1 << (s == 0 ? 23 : 24 + s)));
      dp.dp_op(1'b1, 5'(s), FMT_SINGLE, 64'h0, 1'b0, e);
      // the word updates at the edge the model returns on; look once it has settled
      @(negedge core_clk);
      check(fp_control_status_word, 32'h0040_0f0f);
    end
    // software reads back the word after all condition updates
    apb(1'b0, 12'h000, 32'h0);
    check(rv, 32'h0040_0f0f);
  endtask : t_cc
  task automatic t_exc();
    apb(1'b1, 12'h000, 32'h0002_0000);
    dp.dp_op(1'b0, 5'h14, FMT_WORD, 64'h1234, 1'b1, e);
    check(e, 1'b1);
    rd(5'h14, FMT_WORD, 64'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, (32'h1000 << i) | (32'h80 << ((i + 1) % 5)));
      dp.dp_op(1'b0, 5'h14, FMT_WORD, 64'h77, 1'b1, e);
      check(e, 1'b0);
      apb(1'b1, 12'h000, (32'h1000 << i) | (32'h80 << i));
      dp.dp_op(1'b0, 5'h14, FMT_WORD, 64'h99, 1'b1, e);
      check(e, 1'b1);
      rd(5'h14, FMT_WORD, 64'h77);
    end
    // the status register records that an exception was raised, mode bit low
    apb(1'b0, 12'h004, 32'h0);
    check(rv, 32'h0000_0001);
    // unmapped offset is refused
    apb(1'b0, 12'h0ff, 32'h0);
    check(er, 1'b1);
  endtask : t_exc
  task automatic t_paired();
    rd(5'h4, FMT_DOUBLE, 64'h0);
    dp.dp_op(1'b0, 5'h4, FMT_DOUBLE, 64'h1111_2222_3333_4444, 1'b0, e);
    rd(5'h4, FMT_DOUBLE, 64'h1111_2222_3333_4444);
    rd(5'h5, FMT_SINGLE, 64'h1111_2222);
    rd(5'h5, FMT_DOUBLE, 64'h0);
    rd(5'h4, FMT_LONG, 64'h0);
    rd(5'h4, FMT_PAIRED, 64'h0);
    dp.dp_op(1'b0, 5'h5, FMT_SINGLE, 64'h0000_bbbb, 1'b0, e);
    rd(5'h4, FMT_DOUBLE, 64'h0000_bbbb_3333_4444);
  endtask : t_paired
  initial begin
    do_reset(1'b0);
    t_full();
    t_cc();
    t_exc();
    do_reset(1'b1);
    t_paired();
    give_verdict();
  end
endmodule : test_fp_register_access_and_flags
`default_nettype wire
